// file: ssp_pkg.sv
/*
 * Package for the serial port status/control register bank: offsets,
 * field positions, reset values, mode codes and status event carrier.
 * Assumes one 50 MHz system clock shared by every user of the package.
 */
package ssp_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int         ADDR_W          = 4;
	localparam logic [3:0] OFS_STATUS      = 4'h0;
	localparam logic [3:0] OFS_CONTROL_ONE = 4'h1;
	localparam logic [3:0] OFS_BUFFER      = 4'h2;
	localparam logic [3:0] OFS_RELOAD      = 4'h3;
	localparam logic [3:0] OFS_REQUESTS    = 4'h4;
	localparam logic [7:0] RST_STATUS      = 8'h00;
	localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_ZERO        = 8'h00;

	// ------------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------------
	localparam int ST_SAMPLE = 7;
	localparam int ST_EDGE   = 6;
	localparam int ST_DATA   = 5;
	localparam int ST_STOP   = 4;
	localparam int ST_START  = 3;
	localparam int ST_RW     = 2;
	localparam int ST_UPDATE = 1;
	localparam int ST_FULL   = 0;

	// ------------------------------------------------------------------
	// Control one fields
	// ------------------------------------------------------------------
	localparam int C1_WRITE_COLLISION_FLAG = 7;
	localparam int C1_OVF  = 6;
	localparam int C1_EN   = 5;
	localparam int C1_CKP  = 4;

	// Request register bit positions
	localparam int RQ_START   = 0;
	localparam int RQ_RESTART = 1;
	localparam int RQ_STOP    = 2;
	localparam int RQ_RECV    = 3;
	localparam int RQ_ACK     = 4;

	typedef enum logic [3:0] {
		SSP_SPI_M_DIV4    = 4'b0000,
		SSP_SPI_M_DIV16   = 4'b0001,
		SSP_SPI_M_DIV64   = 4'b0010,
		SSP_SPI_M_TMR     = 4'b0011,
		SSP_SPI_S_SS      = 4'b0100,
		SSP_SPI_S_NOSS    = 4'b0101,
		SSP_I2C_S7        = 4'b0110,
		SSP_I2C_S10       = 4'b0111,
		SSP_I2C_M         = 4'b1000,
		SSP_RSV9          = 4'b1001,
		SSP_SPI_M_RELOAD  = 4'b1010,
		SSP_I2C_FW        = 4'b1011,
		SSP_RSVC          = 4'b1100,
		SSP_RSVD          = 4'b1101,
		SSP_I2C_S7_INT    = 4'b1110,
		SSP_I2C_S10_INT   = 4'b1111
	} ssp_mode_t;

	// Clock dividers in system clocks per SPI half period
	localparam logic [7:0] DIV4_HALF  = 8'h02;
	localparam logic [7:0] DIV16_HALF = 8'h08;
	localparam logic [7:0] DIV64_HALF = 8'h20;

	// Events reported by the shifting engine
	typedef struct packed {
		logic byte_done;
		logic byte_is_data;
		logic start_seen;
		logic stop_seen;
		logic nack_seen;
		logic addr_match;
		logic addr_rw;
		logic addr_high_done;
		logic tx_active;
		logic tx_done;
		logic [7:0] rx_byte;
	} ssp_event_t;

endpackage : ssp_pkg

// file: ssp_regs.sv
/*
 * Status and first control register of a synchronous serial port
 * (SPI master/slave, I2C master/slave), with the transfer buffer, reload
 * value and master request bits that steer them, and the SPI clock
 * generator. Assumes the shifting engine reports events on i_evt in the
 * system clock domain and that i_tmr_match is a one-cycle pulse.
 */
`timescale 1ns/1ps
module ssp_regs
	import ssp_pkg::*;
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_n,
	input  wire logic [ssp_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [7:0]                 i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic      [7:0]                 o_rdata,
	input  wire ssp_pkg::ssp_event_t        i_evt,
	input  wire logic                       i_tmr_match,
	output logic                            o_port_enable,
	output logic                            o_spi_mode,
	output logic                            o_i2c_mode,
	output logic                            o_master,
	output logic                            o_ss_enable,
	output logic                            o_sample_late,
	output logic                            o_shift_on_return,
	output logic                            o_slew_ctrl_en,
	output logic                            o_smbus_levels,
	output logic                            o_sck_idle_high,
	output logic                            o_scl_hold,
	output logic                            o_bit_tick,
	output logic                            o_i2c_busy,
	output logic                            o_tx_start,
	output logic      [7:0]                 o_tx_byte,
	output logic      [7:0]                 o_reload
);
	import ssp_pkg::*;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] status_reg;
	logic [7:0] control_one_reg;
	logic [7:0] buffer_reg;
	logic [7:0] reload_reg;
	logic [4:0] request_reg;
	logic [7:0] div_cnt_reg;
	logic       tmr_half_reg;
	logic       tx_busy_reg;
	ssp_mode_t  mode;
	logic       en;
	logic       wr_status, wr_ctl, wr_buf, wr_rld, wr_req, rd_buf;
	logic       buf_write_ok;
	logic       i2c_slave;

	assign mode      = ssp_mode_t'(control_one_reg[3:0]);
	assign en        = control_one_reg[C1_EN];
	assign wr_status = i_wr && (i_addr == OFS_STATUS);
	assign wr_ctl    = i_wr && (i_addr == OFS_CONTROL_ONE);
	assign wr_buf    = i_wr && (i_addr == OFS_BUFFER);
	assign wr_rld    = i_wr && (i_addr == OFS_RELOAD);
	assign wr_req    = i_wr && (i_addr == OFS_REQUESTS);
	assign rd_buf    = i_rd && (i_addr == OFS_BUFFER);

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	always_comb begin
		o_spi_mode  = 1'b0;
		o_i2c_mode  = 1'b0;
		o_master    = 1'b0;
		o_ss_enable = 1'b0;
		i2c_slave   = 1'b0;
		unique case (mode)
			SSP_SPI_M_DIV4, SSP_SPI_M_DIV16, SSP_SPI_M_DIV64,
			SSP_SPI_M_TMR, SSP_SPI_M_RELOAD: begin
				o_spi_mode = 1'b1;
				o_master   = 1'b1;
			end
			SSP_SPI_S_SS: begin
				o_spi_mode  = 1'b1;
				o_ss_enable = 1'b1;
			end
			SSP_SPI_S_NOSS: begin
				o_spi_mode = 1'b1;
			end
			SSP_I2C_S7, SSP_I2C_S10,
			SSP_I2C_S7_INT, SSP_I2C_S10_INT: begin
				o_i2c_mode = 1'b1;
				i2c_slave  = 1'b1;
			end
			SSP_I2C_M, SSP_I2C_FW: begin
				o_i2c_mode = 1'b1;
				o_master   = 1'b1;
			end
			SSP_RSV9, SSP_RSVC, SSP_RSVD: begin
				// Reserved codes leave the port inert
			end
		endcase
	end

	assign o_port_enable     = en && (o_spi_mode || o_i2c_mode);
	assign o_sample_late     = o_spi_mode && o_master
		&& status_reg[ST_SAMPLE];
	assign o_shift_on_return = o_spi_mode && status_reg[ST_EDGE];
	assign o_smbus_levels    = o_i2c_mode && status_reg[ST_EDGE];
	assign o_slew_ctrl_en    = o_i2c_mode
		&& !status_reg[ST_SAMPLE];
	assign o_sck_idle_high   = o_spi_mode
		&& control_one_reg[C1_CKP];
	assign o_scl_hold        = o_port_enable && i2c_slave
		&& !control_one_reg[C1_CKP];
	assign o_i2c_busy        = o_i2c_mode && o_master
		&& (status_reg[ST_RW] || (|request_reg));
	assign o_reload          = reload_reg;
	assign o_tx_byte         = buffer_reg;

	// A buffer write starts a transfer only when the link can take it
	assign buf_write_ok = o_port_enable && (o_i2c_mode
		? (o_master ? !o_i2c_busy : !tx_busy_reg)
		: !(tx_busy_reg && !o_master));
	assign o_tx_start   = wr_buf && buf_write_ok;

	// ------------------------------------------------------------------
	// SPI master clock generator
	// ------------------------------------------------------------------
	logic [7:0] half_len;
	always_comb begin
		unique case (mode)
			SSP_SPI_M_DIV16:  half_len = DIV16_HALF;
			SSP_SPI_M_DIV64:  half_len = DIV64_HALF;
			SSP_SPI_M_RELOAD: half_len = 8'((reload_reg + 8'h01) << 1);
			default:          half_len = DIV4_HALF;
		endcase
	end

	// Timer source halves the match rate: toggle, tick on each fall
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_port_enable)
			tmr_half_reg <= 1'b0;
		else if (i_tmr_match)
			tmr_half_reg <= !tmr_half_reg;
	end

	// Reload of 127 or 255 wraps the product to zero; software must avoid it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_port_enable || !o_master || !o_spi_mode)
			div_cnt_reg <= RST_ZERO;
		else if (div_cnt_reg + 8'h01 >= half_len)
			div_cnt_reg <= RST_ZERO;
		else
			div_cnt_reg <= div_cnt_reg + 8'h01;
	end

	always_comb begin
		if (!(o_port_enable && o_master && o_spi_mode))
			o_bit_tick = 1'b0;
		else if (mode == SSP_SPI_M_TMR)
			o_bit_tick = i_tmr_match && tmr_half_reg;
		else
			o_bit_tick = (div_cnt_reg + 8'h01 >= half_len);
	end

	// ------------------------------------------------------------------
	// Control one: writable bits and sticky flags
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			control_one_reg <= RST_CONTROL_ONE;
		end else begin
			if (wr_ctl) begin
				control_one_reg[5:0] <= i_wdata[5:0];
				// Software may only clear the flags
				if (!i_wdata[C1_WRITE_COLLISION_FLAG])
					control_one_reg[C1_WRITE_COLLISION_FLAG] <= 1'b0;
				if (!i_wdata[C1_OVF])
					control_one_reg[C1_OVF] <= 1'b0;
			end
			// Set wins over a clear in the same cycle
			if (wr_buf && !buf_write_ok && o_port_enable)
				control_one_reg[C1_WRITE_COLLISION_FLAG] <= 1'b1;
			if (i_evt.byte_done && !i_evt.tx_active && status_reg[ST_FULL]
				&& o_port_enable && !(o_spi_mode && o_master))
				control_one_reg[C1_OVF] <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Buffer and transmit tracking
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n)
			buffer_reg <= RST_ZERO;
		else if (o_tx_start)
			buffer_reg <= i_wdata;
		else if (i_evt.byte_done && !i_evt.tx_active
			&& !status_reg[ST_FULL])
			buffer_reg <= i_evt.rx_byte;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_port_enable)
			tx_busy_reg <= 1'b0;
		else if (o_tx_start)
			tx_busy_reg <= 1'b1;
		else if (i_evt.tx_done)
			tx_busy_reg <= 1'b0;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n)
			reload_reg <= RST_ZERO;
		else if (wr_rld)
			reload_reg <= i_wdata;
	end

	// Requests are refused while the master is busy, cleared when done
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_port_enable || !o_master || !o_i2c_mode)
			request_reg <= 5'b0_0000;
		else if (wr_req && !o_i2c_busy)
			request_reg <= i_wdata[4:0];
		else if (i_evt.start_seen || i_evt.stop_seen || i_evt.byte_done)
			request_reg <= 5'b0_0000;
	end

	// ------------------------------------------------------------------
	// Status register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			status_reg <= RST_STATUS;
		end else begin
			if (wr_status)
				status_reg[ST_SAMPLE:ST_EDGE] <= i_wdata[7:6];
			if (!en) begin
				status_reg[ST_STOP]  <= 1'b0;
				status_reg[ST_START] <= 1'b0;
			end else if (o_i2c_mode) begin
				if (i_evt.start_seen) begin
					status_reg[ST_START] <= 1'b1;
					status_reg[ST_STOP]  <= 1'b0;
				end else if (i_evt.stop_seen) begin
					status_reg[ST_STOP]  <= 1'b1;
					status_reg[ST_START] <= 1'b0;
				end
				if (i_evt.byte_done)
					status_reg[ST_DATA] <= i_evt.byte_is_data;
			end
			if (o_i2c_mode && o_master)
				status_reg[ST_RW] <= tx_busy_reg || o_tx_start;
			else if (i2c_slave && i_evt.addr_match)
				status_reg[ST_RW] <= i_evt.addr_rw;
			else if (i2c_slave && (i_evt.start_seen || i_evt.stop_seen
				|| i_evt.nack_seen))
				status_reg[ST_RW] <= 1'b0;
			if (wr_rld)
				status_reg[ST_UPDATE] <= 1'b0;
			if ((mode == SSP_I2C_S10 || mode == SSP_I2C_S10_INT)
				&& i_evt.addr_high_done)
				status_reg[ST_UPDATE] <= 1'b1;
			// Receive fills, reading the buffer empties it
			if (rd_buf)
				status_reg[ST_FULL] <= 1'b0;
			if (o_tx_start && o_i2c_mode)
				status_reg[ST_FULL] <= 1'b1;
			else if (i_evt.tx_done && o_i2c_mode)
				status_reg[ST_FULL] <= 1'b0;
			else if (i_evt.byte_done && !i_evt.tx_active && o_port_enable)
				status_reg[ST_FULL] <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n)
			o_rdata <= RST_ZERO;
		else if (i_rd) begin
			unique case (i_addr)
				OFS_STATUS:      o_rdata <= status_reg;
				OFS_CONTROL_ONE: o_rdata <= control_one_reg;
				OFS_BUFFER:      o_rdata <= buffer_reg;
				OFS_RELOAD:      o_rdata <= reload_reg;
				OFS_REQUESTS:    o_rdata <= {3'b000, request_reg};
				default:         o_rdata <= RST_ZERO;
			endcase
		end else
			o_rdata <= RST_ZERO;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_stop_start_off: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) !en |=> !status_reg[ST_STOP]
		&& !status_reg[ST_START])
		else $error("condition flags not cleared when disabled");
	chk_write_collision_flag_set: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) wr_buf && o_port_enable && !buf_write_ok
		|=> control_one_reg[C1_WRITE_COLLISION_FLAG])
		else $error("write collision not flagged");
	chk_write_collision_flag_sticky: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) control_one_reg[C1_WRITE_COLLISION_FLAG]
		&& !(wr_ctl && !i_wdata[C1_WRITE_COLLISION_FLAG]) |=> control_one_reg[C1_WRITE_COLLISION_FLAG])
		else $error("write collision cleared by hardware");
	chk_ovf_master: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) o_spi_mode && o_master
		&& !control_one_reg[C1_OVF] && $stable(mode)
		|=> !control_one_reg[C1_OVF])
		else $error("overflow set in SPI master");
	chk_ovf_keep_buf: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) i_evt.byte_done && !i_evt.tx_active
		&& status_reg[ST_FULL] && !o_tx_start |=> $stable(buffer_reg))
		else $error("buffer overwritten on overflow");
	chk_full_on_rx: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) i_evt.byte_done && !i_evt.tx_active
		&& o_port_enable && !i_evt.tx_done |=> status_reg[ST_FULL])
		else $error("buffer full not set on receive");
	chk_full_tx_done: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) i_evt.tx_done && o_i2c_mode && !o_tx_start
		|=> !status_reg[ST_FULL])
		else $error("buffer full not cleared after transmit");
	chk_busy_or: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) o_i2c_mode && o_master && (|request_reg)
		|-> o_i2c_busy)
		else $error("busy misses pending request");
	chk_ckp_hold: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) o_scl_hold |-> i2c_slave && en)
		else $error("clock held outside I2C slave");
	chk_rw_slave: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) i2c_slave && i_evt.addr_match
		|=> status_reg[ST_RW] == $past(i_evt.addr_rw))
		else $error("direction not captured");

	cov_overflow: cover property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) $rose(control_one_reg[C1_OVF]));
	cov_collision: cover property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) $rose(control_one_reg[C1_WRITE_COLLISION_FLAG]));
	cov_stop_seen: cover property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) $rose(status_reg[ST_STOP]));
	cov_tick: cover property (@(posedge i_clk_sys)
		disable iff (!i_rst_n) o_bit_tick ##1 !o_bit_tick ##1 o_bit_tick);

endmodule : ssp_regs

// file: ssp_engine_model.sv
/*
 * Far-side model of the shifting engine: event pulses on request, a
 * transmit of TX_CYC clocks after each accepted buffer write, and a
 * timer match every fourth clock.
 * Assumes the system clock is shared with the register bank.
 */
`timescale 1ns/1ps
module ssp_engine_model
	import ssp_pkg::*;
#(
	parameter int TX_CYC = 200
)(
	input  wire logic           i_clk_sys,
	input  wire logic           i_tx_start,
	output ssp_pkg::ssp_event_t o_evt,
	output logic                o_tmr_match,
	output int                  o_tx_count
);
	import ssp_pkg::*;

	ssp_event_t cmd_evt = '0;
	logic       tx_act  = 1'b0;
	logic       tx_end  = 1'b0;
	int         tx_left = 0;
	logic [1:0] tmr_cnt = 2'h0;
	int         tx_cnt  = 0;

	assign o_tx_count = tx_cnt;

	// ------------------------------------------------------------------
	// Transmit timing
	// ------------------------------------------------------------------
	// Held long enough that the clock generator can be measured inside it
	always @(posedge i_clk_sys) begin
		tmr_cnt <= tmr_cnt + 2'h1;
		tx_end  <= 1'b0;
		if (i_tx_start) begin
			tx_act     <= 1'b1;
			tx_left    <= TX_CYC;
			tx_cnt     <= tx_cnt + 1;
		end else if (tx_act) begin
			tx_left <= tx_left - 1;
			if (tx_left == 1) begin
				tx_act <= 1'b0;
				tx_end <= 1'b1;
			end
		end
	end

	assign o_tmr_match = (tmr_cnt == 2'h3);

	always_comb begin
		o_evt           = cmd_evt;
		o_evt.tx_active = tx_act;
		o_evt.tx_done   = tx_end;
	end

	// ------------------------------------------------------------------
	// One-cycle event pulse, data byte alongside
	// ------------------------------------------------------------------
	task send(input logic [9:0] f, input logic [7:0] d);
		@(posedge i_clk_sys);
		cmd_evt <= {f, d};
		@(posedge i_clk_sys);
		cmd_evt <= '0;
		#1;
	endtask : send

endmodule : ssp_engine_model

// file: sync_serial_port_status_control_bench.sv
/*
 * Self-checking bench for the serial port status and control registers.
 * Assumes ssp_pkg, ssp_regs and ssp_engine_model are compiled first.
 */
`timescale 1ns/1ps
module sync_serial_port_status_control_bench;
	import ssp_pkg::*;

	localparam int         TX_CYC   = 200;
	localparam logic [9:0] EV_BYTE  = 10'h200;
	localparam logic [9:0] EV_DATA  = 10'h100;
	localparam logic [9:0] EV_START = 10'h080;
	localparam logic [9:0] EV_STOP  = 10'h040;
	localparam logic [9:0] EV_MATCH = 10'h010;
	localparam logic [9:0] EV_RW    = 10'h008;
	localparam logic [9:0] EV_HIGH  = 10'h004;
	localparam logic [9:0] EV_NACK  = 10'h020;
	localparam logic [15:0] SPI_TAB = 16'h043F;
	localparam logic [15:0] I2C_TAB = 16'hC9C0;
	localparam logic [15:0] MST_TAB = 16'h0D0F;
	localparam logic [7:0] TICK_MODE [5] = '{8'h00, 8'h01, 8'h02, 8'h0A,
		8'h03};
	// Reload 3 gives 2*(3+1); timer mode ticks on every second match
	localparam logic [7:0] TICK_GAP [5] = '{DIV4_HALF, DIV16_HALF,
		DIV64_HALF, 8'h08, 8'h08};

	logic              i_clk_sys = 1'b0;
	logic              i_rst_n   = 1'b0;
	logic [ADDR_W-1:0] i_addr    = '0;
	logic [7:0]        i_wdata   = '0;
	logic              i_wr      = 1'b0;
	logic              i_rd      = 1'b0;
	logic [7:0]        o_rdata, o_tx_byte, o_reload;
	logic              o_port_enable, o_spi_mode, o_i2c_mode, o_master;
	logic              o_ss_enable, o_sample_late, o_shift_on_return;
	logic              o_slew_ctrl_en, o_smbus_levels, o_sck_idle_high;
	logic              o_scl_hold, o_bit_tick, o_i2c_busy, o_tx_start;
	ssp_event_t        i_evt;
	logic              i_tmr_match;
	int                tx_count;
	int                bad_count    = 0;
	int                total_checks = 0;
	int                cyc          = 0;
	int                n;
	int                g;
	logic              rd_q = 1'b0;
	logic [19:0]       note;
	logic [19:0]       exp_q [$];
	logic [7:0]        r, d0, d1, m;

	always #10 i_clk_sys = ~i_clk_sys;

	ssp_regs DUT (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_evt, .i_tmr_match, .o_port_enable, .o_spi_mode,
		.o_i2c_mode, .o_master, .o_ss_enable, .o_sample_late,
		.o_shift_on_return, .o_slew_ctrl_en, .o_smbus_levels,
		.o_sck_idle_high, .o_scl_hold, .o_bit_tick, .o_i2c_busy,
		.o_tx_start, .o_tx_byte, .o_reload);

	ssp_engine_model #(.TX_CYC(TX_CYC)) u_eng (.i_clk_sys,
		.i_tx_start(o_tx_start), .o_evt(i_evt), .o_tmr_match(i_tmr_match),
		.o_tx_count(tx_count));

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task report_and_stop;
		$display("Checks %0d, errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data is judged by the monitor in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [7:0] k, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd   <= 1'b1;
		exp_q.push_back({a, k, e & k});
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
	endtask : rd

	task gap(output int c);
		int w;
		w = 0;
		while (o_bit_tick !== 1'b1 && w < 300) begin
			@(posedge i_clk_sys);
			#1;
			w++;
		end
		@(posedge i_clk_sys);
		#1;
		c = 1;
		while (o_bit_tick !== 1'b1 && c < 300) begin
			@(posedge i_clk_sys);
			#1;
			c++;
		end
	endtask : gap

	always @(posedge i_clk_sys) begin
		if (rd_q) begin
			note = exp_q.pop_front();
			chk($sformatf("reg %0h", note[19:16]), o_rdata & note[15:8],
				note[7:0]);
		end
		rd_q <= i_rd;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hcfe7));
		repeat (6) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(4'h0, 8'hFF, RST_STATUS);
		rd(4'h1, 8'hFF, RST_CONTROL_ONE);
		rd(4'hF, 8'hFF, 8'h00);
		wr(4'h0, 8'h3F);
		rd(4'h0, 8'hFF, 8'h00);
		chk("enable", 8'(o_port_enable), 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(4'h1, 8'h20 | 8'(i));
			// Reserved codes leave the pins with general I/O
			chk("enable", 8'(o_port_enable),
				8'(SPI_TAB[i] | I2C_TAB[i]));
			chk("spi", 8'(o_spi_mode), 8'(SPI_TAB[i]));
			chk("i2c", 8'(o_i2c_mode), 8'(I2C_TAB[i]));
			chk("master", 8'(o_master), 8'(MST_TAB[i]));
			chk("ss", 8'(o_ss_enable), 8'(i == 4));
		end
		r = 8'($urandom);
		wr(4'h1, 8'h20 | (r & 8'h10));
		wr(4'h0, r);
		rd(4'h0, 8'hFF, r & 8'hC0);
		chk("sample", 8'(o_sample_late), 8'(r[7]));
		chk("edge", 8'(o_shift_on_return), 8'(r[6]));
		chk("idle", 8'(o_sck_idle_high), 8'(r[4]));
		wr(4'h1, 8'h28);
		chk("slew", 8'(o_slew_ctrl_en), 8'(!r[7]));
		chk("smbus", 8'(o_smbus_levels), 8'(r[6]));
		wr(4'h1, 8'h26);
		chk("hold", 8'(o_scl_hold), 8'h01);
		d0 = 8'($urandom);
		d1 = ~d0;
		u_eng.send(EV_BYTE | EV_DATA, d0);
		rd(4'h0, 8'h21, 8'h21);
		u_eng.send(EV_BYTE | EV_DATA, d1);
		rd(4'h1, 8'hFF, 8'h66);
		rd(4'h2, 8'hFF, d0);
		rd(4'h0, 8'h01, 8'h00);
		u_eng.send(EV_BYTE | EV_MATCH | EV_RW, 8'h00);
		rd(4'h0, 8'h24, 8'h04);
		u_eng.send(EV_NACK, 8'h00);
		rd(4'h0, 8'h04, 8'h00);
		wr(4'h1, 8'h36);
		chk("hold", 8'(o_scl_hold), 8'h00);
		rd(4'h2, 8'hFF, 8'h00);
		wr(4'h1, 8'h28);
		n = tx_count;
		wr(4'h2, 8'hA5);
		chk("txstart", 8'(tx_count - n), 8'h01);
		chk("txbyte", o_tx_byte, 8'hA5);
		rd(4'h0, 8'h05, 8'h05);
		chk("busy", 8'(o_i2c_busy), 8'h01);
		repeat (TX_CYC + 4) @(posedge i_clk_sys);
		rd(4'h0, 8'h05, 8'h00);
		chk("busy", 8'(o_i2c_busy), 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(4'h4, 8'(1 << i));
			chk("busy", 8'(o_i2c_busy), 8'h01);
			u_eng.send(EV_STOP, 8'h00);
		end
		wr(4'h4, 8'h01);
		n = tx_count;
		wr(4'h2, 8'h55);
		rd(4'h1, 8'hFF, 8'hA8);
		chk("txstart", 8'(tx_count - n), 8'h00);
		chk("txbyte", o_tx_byte, 8'hA5);
		u_eng.send(EV_START, 8'h00);
		rd(4'h0, 8'h18, 8'h08);
		chk("busy", 8'(o_i2c_busy), 8'h00);
		u_eng.send(EV_STOP, 8'h00);
		rd(4'h0, 8'h18, 8'h10);
		wr(4'h1, 8'h28);
		rd(4'h1, 8'hFF, 8'h28);
		wr(4'h1, 8'h08);
		rd(4'h0, 8'h18, 8'h00);
		chk("enable", 8'(o_port_enable), 8'h00);
		for (int k = 0; k < 2; k++) begin
			m = (k == 0) ? 8'h24 : 8'h20;
			wr(4'h0, 8'h00);
			wr(4'h1, m);
			u_eng.send(EV_BYTE, d0);
			u_eng.send(EV_BYTE, d1);
			rd(4'h1, 8'hFF, (k == 0) ? 8'h64 : 8'h20);
			rd(4'h2, 8'hFF, d0);
			rd(4'h0, 8'h01, 8'h00);
		end
		wr(4'h1, 8'h27);
		u_eng.send(EV_HIGH, 8'h00);
		rd(4'h0, 8'h02, 8'h02);
		wr(4'h3, 8'h03);
		rd(4'h0, 8'h02, 8'h00);
		chk("reload", o_reload, 8'h03);
		for (int k = 0; k < 5; k++) begin
			wr(4'h1, 8'h20 | TICK_MODE[k]);
			repeat (TX_CYC + 4) @(posedge i_clk_sys);
			wr(4'h2, 8'($urandom));
			gap(g);
			chk("tick", 8'(g), TICK_GAP[k]);
		end
		// Reset in mid-run while a transmit may still be counting down
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(4'h1, 8'hFF, RST_CONTROL_ONE);
		rd(4'h3, 8'hFF, RST_ZERO);
		rd(4'h0, 8'hFF, RST_STATUS);
		chk("enable", 8'(o_port_enable), 8'h00);
		chk("tick", 8'(o_bit_tick), 8'h00);
		repeat (3) @(posedge i_clk_sys);
		report_and_stop();
	end

endmodule : sync_serial_port_status_control_bench
